// *** mfc_top.sv ***
// counter io block: totalizer, two digital ports, dac codes
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - count input pulses up to 100 kHz without losing any
// - 26-bit totalizer wraps from 67,108,863 to zero and keeps counting
// - configuration bit picks rising or falling input edges for counting
// - count readable any time and capturable as a scan step
// - active-high gate permits counting when high, inhibits when low
// - active-low gate permits counting when low, inhibits when high
// - count only while both gates enable; either or both may be used
// - unconnected gate floats to its enabling level
// - two separate 8-bit bidirectional ports usable for reading patterns
// - port levels readable immediately or captured as a scan step
// - alarm on port pattern match or on change of selected bits
// - pattern alarms work whether or not the port is scanned
// - open port input reads one, grounded input reads zero
// - output ports writable together as one 16-bit word or singly
// - each of two analog channels set by a 16-bit code
// - analog setting spans -12 V to +12 V in 1 mV steps
module mfc_top
   import mfc_pkg::*;
(
   // clock, reset, enable
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_ce,
   // avalon-mm slave
   input  wire logic [7:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic      [31:0]       o_avs_readdata,
   output logic                   o_avs_waitrequest,
   // interrupt
   output logic                   o_irq,
   // totalizer pins
   input  wire logic              i_tot_in,
   input  wire logic              i_gate_hi,
   input  wire logic              i_gate_lo_b,
   // digital port pins, 15:8 is the second port
   input  wire logic [WORD_W-1:0] i_port_in,
   output logic      [WORD_W-1:0] o_port_out,
   output logic      [WORD_W-1:0] o_port_oe,
   // dac setting codes, signed millivolts
   output logic      [DAC_W-1:0]  o_dac0_code,
   output logic      [DAC_W-1:0]  o_dac1_code
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic                 ack_r;
   logic                 req;
   logic                 acc;
   logic                 wr_acc;
   logic                 rd_acc;
   logic [31:0]          rdata_r;
   logic [31:0]          rd_mux;
   logic                 fall_r;
   logic                 clear_r;
   logic [TOT_W-1:0]     count_r;
   logic                 tot_prev_r;
   logic [2:0]           tot_sync;
   logic                 tot_edge;
   logic                 gate_ok;
   logic                 tot_inc;
   logic                 tot_wrap;
   logic [WORD_W-1:0]    port_sync;
   logic [WORD_W-1:0]    port_out_r;
   logic [WORD_W-1:0]    port_dir_r;
   logic [WORD_W-1:0]    alm_pat_r;
   logic [WORD_W-1:0]    alm_mask_r;
   logic [3:0]           alm_mode_r;
   logic [NPORT-1:0]     alm_evt;
   logic [DAC_W-1:0]     dac0_r;
   logic [DAC_W-1:0]     dac1_r;
   mfc_scan_e            scan_src_r;
   logic [31:0]          scan_data_r;
   logic [IRQ_W-1:0]     irq_stat_r;
   logic [IRQ_W-1:0]     irq_mask_r;
   logic [IRQ_W-1:0]     irq_evt;
   logic [31:0]          wmask;
   logic [31:0]          wdata_m;

   // ----------------------------------------------------------------
   // dac code clamp
   // ----------------------------------------------------------------
   // out-of-range writes saturate at the span ends rather than wrap
   function automatic logic [DAC_W-1:0] dac_clamp(input logic [DAC_W-1:0] code);
      logic signed [DAC_W-1:0] s;
      s = signed'(code);
      if (s > DAC_MAX_MV) begin
         dac_clamp = DAC_MAX_MV;
      end else if (s < DAC_MIN_MV) begin
         dac_clamp = DAC_MIN_MV;
      end else begin
         dac_clamp = code;
      end
   endfunction : dac_clamp

   // ----------------------------------------------------------------
   // avalon-mm handshake
   // ----------------------------------------------------------------
   // one wait cycle: read data is fetched while waitrequest is high
   assign req               = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~(ack_r & i_ce);
   assign acc               = req & ack_r & i_ce;
   assign wr_acc            = acc & i_avs_write;
   assign rd_acc            = acc & i_avs_read;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ack_r <= 1'b0;
      end else if (i_ce) begin
         ack_r <= req & ~ack_r;
      end
   end

   // byte enables widened to a bit mask
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_be
         assign wmask[gb*8 +: 8] = {8{i_avs_byteenable[gb]}};
      end
   endgenerate
   assign wdata_m = i_avs_writedata & wmask;

   // ----------------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------------
   // unmapped offsets read as zero
   always_comb begin
      rd_mux = '0;
      unique case (i_avs_address)
         OFS_CTRL:      rd_mux[CTRL_FALL_BIT] = fall_r;
         OFS_TOT_COUNT: rd_mux[TOT_W-1:0]     = count_r;
         OFS_PORT_IN:   rd_mux[WORD_W-1:0]    = port_sync;
         OFS_PORT_OUT:  rd_mux[WORD_W-1:0]    = port_out_r;
         OFS_PORT_DIR:  rd_mux[WORD_W-1:0]    = port_dir_r;
         OFS_ALM_PAT:   rd_mux[WORD_W-1:0]    = alm_pat_r;
         OFS_ALM_MASK:  rd_mux[WORD_W-1:0]    = alm_mask_r;
         OFS_ALM_MODE:  rd_mux[3:0]           = alm_mode_r;
         OFS_DAC0:      rd_mux[DAC_W-1:0]     = dac0_r;
         OFS_DAC1:      rd_mux[DAC_W-1:0]     = dac1_r;
         OFS_SCAN_CMD:  rd_mux[1:0]           = scan_src_r;
         OFS_SCAN_DATA: rd_mux                = scan_data_r;
         OFS_IRQ_STAT:  rd_mux[IRQ_W-1:0]     = irq_stat_r;
         OFS_IRQ_MASK:  rd_mux[IRQ_W-1:0]     = irq_mask_r;
         default:       rd_mux                = '0;
      endcase
   end

   // data registered in the wait cycle so it stands at the accept edge
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         rdata_r <= '0;
      end else if (i_ce && i_avs_read && !ack_r) begin
         rdata_r <= rd_mux;
      end
   end
   assign o_avs_readdata = rdata_r;

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   // clear is a one-cycle strobe, it never reads back as set
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         fall_r  <= 1'b0;
         clear_r <= 1'b0;
      end else if (i_ce) begin
         clear_r <= 1'b0;
         if (wr_acc && i_avs_address == OFS_CTRL && i_avs_byteenable[0]) begin
            fall_r  <= i_avs_writedata[CTRL_FALL_BIT];
            clear_r <= i_avs_writedata[CTRL_CLEAR_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // totalizer input conditioning
   // ----------------------------------------------------------------
   // open gates sit enabled by pad pulls
   mfc_sync #(
      .W (3)
   ) u_tot_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_async ({i_gate_lo_b, i_gate_hi, i_tot_in}),
      .o_sync  (tot_sync)
   );

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         tot_prev_r <= 1'b0;
      end else if (i_ce) begin
         tot_prev_r <= tot_sync[0];
      end
   end

   // 400 clocks per input period at 100 kHz
   assign tot_edge = fall_r ? (tot_prev_r & ~tot_sync[0])
                            : (~tot_prev_r & tot_sync[0]);
   assign gate_ok  = tot_sync[1] & ~tot_sync[2];
   assign tot_inc  = tot_edge & gate_ok;
   assign tot_wrap = tot_inc & (count_r == TOT_MAX);

   // ----------------------------------------------------------------
   // totalizer counter
   // ----------------------------------------------------------------
   // a software clear wins over a coincident count
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         count_r <= '0;
      end else if (i_ce) begin
         if (clear_r) begin
            count_r <= '0;
         end else if (tot_wrap) begin
            count_r <= '0;
         end else if (tot_inc) begin
            count_r <= count_r + 26'h0000001;
         end
      end
   end

   // ----------------------------------------------------------------
   // digital ports
   // ----------------------------------------------------------------
   // open inputs read high through pad pull-ups
   mfc_sync #(
      .W (WORD_W)
   ) u_port_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .i_async (i_port_in),
      .o_sync  (port_sync)
   );

   // byte lanes let each port be written alone or both as one word
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         port_out_r <= RST_PORT_OUT;
         port_dir_r <= RST_PORT_DIR;
      end else if (i_ce && wr_acc) begin
         if (i_avs_address == OFS_PORT_OUT) begin
            port_out_r <= (port_out_r & ~wmask[WORD_W-1:0]) | wdata_m[WORD_W-1:0];
         end
         if (i_avs_address == OFS_PORT_DIR) begin
            port_dir_r <= (port_dir_r & ~wmask[WORD_W-1:0]) | wdata_m[WORD_W-1:0];
         end
      end
   end

   assign o_port_out = port_out_r;
   assign o_port_oe  = port_dir_r;

   // ----------------------------------------------------------------
   // pattern alarms
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         alm_pat_r  <= '0;
         alm_mask_r <= '0;
         alm_mode_r <= '0;
      end else if (i_ce && wr_acc) begin
         if (i_avs_address == OFS_ALM_PAT) begin
            alm_pat_r <= (alm_pat_r & ~wmask[WORD_W-1:0]) | wdata_m[WORD_W-1:0];
         end
         if (i_avs_address == OFS_ALM_MASK) begin
            alm_mask_r <= (alm_mask_r & ~wmask[WORD_W-1:0]) | wdata_m[WORD_W-1:0];
         end
         if (i_avs_address == OFS_ALM_MODE && i_avs_byteenable[0]) begin
            alm_mode_r <= i_avs_writedata[3:0];
         end
      end
   end

   // alarms watch live pins, scanned or not
   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_alm
         mfc_alarm u_alarm (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_ce    (i_ce),
            .i_bits  (port_sync[gp*PORT_W +: PORT_W]),
            .i_cfg   ({alm_mode_r[MODE_EN_BIT+gp], alm_mode_r[MODE_CHG_BIT+gp],
                       alm_mask_r[gp*PORT_W +: PORT_W], alm_pat_r[gp*PORT_W +: PORT_W]}),
            .o_event (alm_evt[gp])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // scan step capture
   // ----------------------------------------------------------------
   // a source write selects and snapshots in one step
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         scan_src_r  <= MFC_SCAN_TOT;
         scan_data_r <= '0;
      end else if (i_ce && wr_acc && i_avs_address == OFS_SCAN_CMD) begin
         scan_src_r <= mfc_scan_e'(i_avs_writedata[1:0]);
         unique case (mfc_scan_e'(i_avs_writedata[1:0]))
            MFC_SCAN_TOT:   scan_data_r <= {6'h00, count_r};
            MFC_SCAN_PORT0: scan_data_r <= {24'h000000, port_sync[7:0]};
            MFC_SCAN_PORT1: scan_data_r <= {24'h000000, port_sync[15:8]};
            MFC_SCAN_WORD:  scan_data_r <= {16'h0000, port_sync};
         endcase
      end
   end

   // ----------------------------------------------------------------
   // dac settings
   // ----------------------------------------------------------------
   // code is signed millivolts, one count per 1 mV step
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         dac0_r <= RST_DAC;
         dac1_r <= RST_DAC;
      end else if (i_ce && wr_acc && i_avs_byteenable[1:0] == 2'h3) begin
         if (i_avs_address == OFS_DAC0) begin
            dac0_r <= dac_clamp(i_avs_writedata[DAC_W-1:0]);
         end
         if (i_avs_address == OFS_DAC1) begin
            dac1_r <= dac_clamp(i_avs_writedata[DAC_W-1:0]);
         end
      end
   end

   assign o_dac0_code = dac0_r;
   assign o_dac1_code = dac1_r;

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   assign irq_evt = {tot_wrap, alm_evt};

   // a read clears only the bits it returned; a same-cycle event still sets
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         irq_stat_r <= '0;
      end else if (i_ce) begin
         if (rd_acc && i_avs_address == OFS_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~rdata_r[IRQ_W-1:0]) | irq_evt;
         end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         irq_mask_r <= '0;
      end else if (i_ce && wr_acc && i_avs_address == OFS_IRQ_MASK && i_avs_byteenable[0]) begin
         irq_mask_r <= i_avs_writedata[IRQ_W-1:0];
      end
   end

   // level output, high while any enabled status bit stands
   assign o_irq = |(irq_stat_r & irq_mask_r);

endmodule : mfc_top
`default_nettype wire

// *** mfc_pkg.sv ***
// package: register map, fields, reset values and timing of the counter io
package mfc_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_KHZ          = 40000;
   localparam int unsigned TOT_MAX_RATE_KHZ = 100;
   // cycles per input period at the highest rated pulse rate
   localparam int unsigned TOT_MIN_PERIOD_CYC = CLK_KHZ / TOT_MAX_RATE_KHZ;

   // ----------------------------------------------------------------
   // widths and limits
   // ----------------------------------------------------------------
   localparam int unsigned TOT_W    = 26;
   localparam int unsigned PORT_W   = 8;
   localparam int unsigned NPORT    = 2;
   localparam int unsigned WORD_W   = PORT_W * NPORT;
   localparam int unsigned DAC_W    = 16;
   localparam logic [TOT_W-1:0]        TOT_MAX     = 26'h3ffffff;
   localparam logic signed [DAC_W-1:0] DAC_MAX_MV  = 16'sh2ee0;
   localparam logic signed [DAC_W-1:0] DAC_MIN_MV  = -16'sh2ee0;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_TOT_COUNT = 8'h04;
   localparam logic [7:0] OFS_PORT_IN   = 8'h08;
   localparam logic [7:0] OFS_PORT_OUT  = 8'h0c;
   localparam logic [7:0] OFS_PORT_DIR  = 8'h10;
   localparam logic [7:0] OFS_ALM_PAT   = 8'h14;
   localparam logic [7:0] OFS_ALM_MASK  = 8'h18;
   localparam logic [7:0] OFS_ALM_MODE  = 8'h1c;
   localparam logic [7:0] OFS_DAC0      = 8'h20;
   localparam logic [7:0] OFS_DAC1      = 8'h24;
   localparam logic [7:0] OFS_SCAN_CMD  = 8'h28;
   localparam logic [7:0] OFS_SCAN_DATA = 8'h2c;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h30;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h34;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_FALL_BIT  = 0;
   localparam int unsigned CTRL_CLEAR_BIT = 1;
   localparam int unsigned MODE_CHG_BIT   = 0;  // plus port index
   localparam int unsigned MODE_EN_BIT    = 2;  // plus port index
   localparam int unsigned IRQ_ALM_BIT    = 0;  // plus port index
   localparam int unsigned IRQ_WRAP_BIT   = 2;
   localparam int unsigned IRQ_W          = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [WORD_W-1:0] RST_PORT_OUT = 16'hffff;
   localparam logic [WORD_W-1:0] RST_PORT_DIR = 16'h0000;
   localparam logic [DAC_W-1:0]  RST_DAC      = 16'h0000;

   // scan step sources
   typedef enum logic [1:0] {
      MFC_SCAN_TOT,
      MFC_SCAN_PORT0,
      MFC_SCAN_PORT1,
      MFC_SCAN_WORD
   } mfc_scan_e;

   // alarm configuration of one port
   typedef struct packed {
      logic              enable;
      logic              change_mode;
      logic [PORT_W-1:0] mask;
      logic [PORT_W-1:0] pattern;
   } mfc_alm_cfg_s;

endpackage : mfc_pkg

// *** mfc_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module mfc_sync
   import mfc_pkg::*;
#(
   parameter int unsigned W = 1
) (
   // clock, reset, enable
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_ce,
   // asynchronous level in, synchronised level out
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   // first stage is read only by the second stage
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta_r <= '0;
         sync_r <= '0;
      end else if (i_ce) begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;
endmodule : mfc_sync
`default_nettype wire

// *** mfc_alarm.sv ***
// pattern match and pattern change alarm for one 8-bit port
`timescale 1ns/100ps
`default_nettype none
module mfc_alarm
   import mfc_pkg::*;
(
   // clock, reset, enable
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_ce,
   // synchronised port bits and configuration
   input  wire logic [PORT_W-1:0] i_bits,
   input  wire mfc_alm_cfg_s      i_cfg,
   // one-cycle alarm event
   output logic                   o_event
);
   logic [PORT_W-1:0] prev_r;
   logic              match_r;
   logic              event_r;
   logic              match;
   logic              change;

   // masked compares against the pattern and the last sample
   assign match  = ((i_bits ^ i_cfg.pattern) & i_cfg.mask) == '0;
   assign change = ((i_bits ^ prev_r) & i_cfg.mask) != '0;

   // match fires once on entry, not every cycle it holds
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         prev_r  <= '0;
         match_r <= 1'b0;
         event_r <= 1'b0;
      end else if (i_ce) begin
         prev_r  <= i_bits;
         match_r <= match;
         event_r <= i_cfg.enable & (i_cfg.change_mode ? change : (match & ~match_r));
      end
   end

   assign o_event = event_r;
endmodule : mfc_alarm
`default_nettype wire

// *** mfc_asserts.sv ***
// checker: bus timing, outputs and interrupt
`timescale 1ns/100ps
`default_nettype none
module mfc_asserts
   import mfc_pkg::*;
(
   // clock, reset, enable
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_ce,
   // avalon-mm slave
   input  wire logic [7:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic              o_avs_waitrequest,
   // interrupt and outputs
   input  wire logic              o_irq,
   input  wire logic [WORD_W-1:0] o_port_out,
   input  wire logic [WORD_W-1:0] o_port_oe,
   input  wire logic [DAC_W-1:0]  o_dac0_code,
   input  wire logic [DAC_W-1:0]  o_dac1_code
);
   // --------
   // helpers
   // --------
   logic req;
   logic acc;
   logic irq_acc;
   // acc: request taken at this edge
   assign req     = i_avs_read | i_avs_write;
   assign acc     = req & ~o_avs_waitrequest;
   assign irq_acc = acc & (i_avs_address == OFS_IRQ_STAT || i_avs_address == OFS_IRQ_MASK);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   wait_first_a: assert property ($rose(req) |-> o_avs_waitrequest)
      else $error("no wait state on new request");
   one_wait_a: assert property ((req && o_avs_waitrequest && i_ce) |=> !o_avs_waitrequest)
      else $error("more than one wait state");
   idle_nowait_a: assert property (!req |-> !o_avs_waitrequest)
      else $error("waitrequest without a request");
   dac_range_a: assert property ($signed(o_dac0_code) >= DAC_MIN_MV &&
      $signed(o_dac0_code) <= DAC_MAX_MV && $signed(o_dac1_code) >= DAC_MIN_MV &&
      $signed(o_dac1_code) <= DAC_MAX_MV)
      else $error("dac code outside range");
   dac_hold_a: assert property (!(acc && i_avs_write && i_avs_address == OFS_DAC0) |=>
      $stable(o_dac0_code))
      else $error("dac0 code moved without a write");
   word_hold_a: assert property (!(acc && i_avs_write && i_avs_address == OFS_PORT_OUT) |=>
      $stable(o_port_out))
      else $error("port output moved without a write");
   oe_hold_a: assert property (!(acc && i_avs_write && i_avs_address == OFS_PORT_DIR) |=>
      $stable(o_port_oe))
      else $error("port direction moved without a write");
   irq_fall_a: assert property ($fell(o_irq) |-> $past(irq_acc))
      else $error("irq fell without status read or mask write");
   out_reset_a: assert property ($rose(i_rst_b) |-> o_port_out == RST_PORT_OUT &&
      o_port_oe == RST_PORT_DIR && o_dac0_code == RST_DAC)
      else $error("outputs not at reset values");
endmodule : mfc_asserts
`default_nettype wire

// *** mfc_pins.sv ***
// model of the pins around the block: pulse source, gates, port contacts
`timescale 1ns/100ps
`default_nettype none
module mfc_pins
   import mfc_pkg::*;
(
   // clock
   input  wire logic              i_clk,
   // driven port levels and enables
   input  wire logic [WORD_W-1:0] o_port_out,
   input  wire logic [WORD_W-1:0] o_port_oe,
   // pins into the block
   output var logic               i_tot_in,
   output var logic               i_gate_hi,
   output var logic               i_gate_lo_b,
   output logic      [WORD_W-1:0] i_port_in
);
   logic [WORD_W-1:0] ext_drv;  // contact closure present
   logic [WORD_W-1:0] ext_val;
   // unwired gates float to enabling level
   initial begin
      i_tot_in = 1'b0;
      i_gate_hi = 1'b1;
      i_gate_lo_b = 1'b0;
      ext_drv = '0;
      ext_val = '0;
   end
   // pull-up unless a contact closes; driven bits win
   assign i_port_in = (o_port_oe & o_port_out) | (~o_port_oe & (~ext_drv | ext_val));
   // pulses at the top rated rate, 200 cycles each level
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (200) @(posedge i_clk);
         i_tot_in <= 1'b1;
         repeat (200) @(posedge i_clk);
         i_tot_in <= 1'b0;
      end
   endtask : pulses
endmodule : mfc_pins
`default_nettype wire

// *** tb_top.sv ***
// testbench: scenarios and verdict for the counter io block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import mfc_pkg::*;
   // --------
   // signals
   // --------
   logic              i_clk = 1'b0;
   logic              i_rst_b = 1'b0;
   logic              i_ce = 1'b1;
   logic [7:0]        i_avs_address = '0;
   logic              i_avs_read = 1'b0;
   logic              i_avs_write = 1'b0;
   logic [31:0]       i_avs_writedata = '0;
   logic [3:0]        i_avs_byteenable = '0;
   logic [31:0]       o_avs_readdata, rdat;
   logic              o_avs_waitrequest, o_irq, i_tot_in, i_gate_hi, i_gate_lo_b;
   logic [WORD_W-1:0] i_port_in, o_port_out, o_port_oe;
   logic [DAC_W-1:0]  o_dac0_code, o_dac1_code;
   int                err_total = 0;
   int                samples_checked = 0;

   mfc_top  mfc_top_i  (.*);
   mfc_pins mfc_pins_i (.*);
   always #12.5 i_clk = ~i_clk;

   // one transfer, held until waitrequest is low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge i_clk);
      i_avs_write <= w;
      i_avs_read <= ~w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
      rdat = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_clk);
   endtask : bus
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(rdat, exp);
   endtask : rd
   task automatic settle();
      repeat (8) @(posedge i_clk);
   endtask : settle

   // reset values and an unmapped offset
   task automatic t_reset();
      rd(OFS_PORT_OUT, 32'h0000ffff);
      rd(OFS_PORT_DIR, 32'h0);
      rd(OFS_DAC0, 32'h0);
      wr(8'h3c, 32'h1234);
      rd(8'h3c, 32'h0);
   endtask : t_reset
   // counting, gating, edge choice and scan capture
   task automatic t_tot();
      wr(OFS_CTRL, 32'h2);
      mfc_pins_i.pulses(3);
      settle();
      rd(OFS_TOT_COUNT, 32'h3);
      mfc_pins_i.i_gate_hi <= 1'b0;
      mfc_pins_i.pulses(2);
      rd(OFS_TOT_COUNT, 32'h3);
      mfc_pins_i.i_gate_hi <= 1'b1;
      mfc_pins_i.i_gate_lo_b <= 1'b1;
      mfc_pins_i.pulses(2);
      rd(OFS_TOT_COUNT, 32'h3);
      mfc_pins_i.i_gate_lo_b <= 1'b0;
      mfc_pins_i.pulses(1);
      settle();
      rd(OFS_TOT_COUNT, 32'h4);
      wr(OFS_CTRL, 32'h1);
      mfc_pins_i.i_tot_in <= 1'b1;
      settle();
      rd(OFS_TOT_COUNT, 32'h4);
      mfc_pins_i.i_tot_in <= 1'b0;
      settle();
      rd(OFS_TOT_COUNT, 32'h5);
      wr(OFS_SCAN_CMD, 32'h0);
      rd(OFS_SCAN_DATA, 32'h5);
      wr(OFS_CTRL, 32'h3);
      settle();
      rd(OFS_TOT_COUNT, 32'h0);
   endtask : t_tot
   // port outputs by byte and word, live and scanned input reads
   task automatic t_port();
      wr(OFS_PORT_DIR, 32'h00ff);
      bus(1'b1, OFS_PORT_OUT, 32'h1234, 4'h3);
      chk({16'h0000, o_port_out}, 32'h1234);
      bus(1'b1, OFS_PORT_OUT, 32'h5600, 4'h2);
      chk({16'h0000, o_port_out}, 32'h5634);
      chk({16'h0000, o_port_oe}, 32'h00ff);
      settle();
      rd(OFS_PORT_IN, 32'h0000ff34);
      mfc_pins_i.ext_drv <= 16'hff00;
      mfc_pins_i.ext_val <= 16'h0f00;
      settle();
      rd(OFS_PORT_IN, 32'h00000f34);
      wr(OFS_SCAN_CMD, 32'h3);
      rd(OFS_SCAN_DATA, 32'h00000f34);
      wr(OFS_SCAN_CMD, 32'h1);
      rd(OFS_SCAN_DATA, 32'h00000034);
      wr(OFS_SCAN_CMD, 32'h2);
      rd(OFS_SCAN_DATA, 32'h0000000f);
   endtask : t_port
   // dac codes at and beyond both ends of the range
   task automatic t_dac();
      logic [15:0] tv [5] = '{16'h2ee0, 16'hd120, 16'h3000, 16'h8000, 16'hffff};
      logic [15:0] ev [5] = '{16'h2ee0, 16'hd120, 16'h2ee0, 16'hd120, 16'hffff};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_DAC0, {16'h0000, tv[i]});
         wr(OFS_DAC1, {16'h0000, tv[4-i]});
         chk({16'h0000, o_dac0_code}, {16'h0000, ev[i]});
         chk({16'h0000, o_dac1_code}, {16'h0000, ev[4-i]});
      end
      rd(OFS_DAC1, 32'h00002ee0);
   endtask : t_dac
   // match alarm raises the interrupt, change alarm while masked
   task automatic t_alarm();
      wr(OFS_PORT_DIR, 32'h0);
      mfc_pins_i.ext_drv <= 16'h00ff;
      mfc_pins_i.ext_val <= 16'h0000;
      wr(OFS_ALM_PAT, 32'h00a5);
      wr(OFS_ALM_MASK, 32'h00ff);
      wr(OFS_ALM_MODE, 32'h4);
      wr(OFS_IRQ_MASK, 32'h7);
      settle();
      rd(OFS_IRQ_STAT, 32'h0);
      mfc_pins_i.ext_val <= 16'h00a5;
      settle();
      chk({31'h0, o_irq}, 32'h1);
      rd(OFS_IRQ_STAT, 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      wr(OFS_IRQ_MASK, 32'h0);
      wr(OFS_ALM_MODE, 32'h5);
      mfc_pins_i.ext_val <= 16'h0081;
      settle();
      chk({31'h0, o_irq}, 32'h0);
      rd(OFS_IRQ_STAT, 32'h1);
      rd(OFS_IRQ_STAT, 32'h0);
   endtask : t_alarm

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      t_reset();
      t_tot();
      t_port();
      t_dac();
      t_alarm();
      results();
   end
   // watchdog well beyond the expected run
   initial begin
      repeat (40000) @(posedge i_clk);
      err_total++;
      results();
   end
endmodule : tb_top
bind mfc_top mfc_asserts mfc_asserts_i (.*);
`default_nettype wire
